// >>> tmc_pkg.sv
package tmc_pkg;
    localparam logic [11:0] CTRL0_ADDR   = 12'h000;
    localparam logic [11:0] CTRL1_ADDR   = 12'h004;
    localparam logic [11:0] CNT_LO_ADDR  = 12'h008;
    localparam logic [11:0] CNT_HI_ADDR  = 12'h00C;
    localparam logic [11:0] CMPA_LO_ADDR = 12'h010;
    localparam logic [11:0] CMPA_HI_ADDR = 12'h014;
    localparam logic [11:0] CMPP_LO_ADDR = 12'h018;
    localparam logic [11:0] CMPP_HI_ADDR = 12'h01C;
    localparam logic [11:0] INT_STAT_ADDR = 12'h020;
    localparam logic [11:0] INT_MASK_ADDR = 12'h024;
    localparam logic [11:0] PDSEL_ADDR   = 12'h028;

    // Control 0 fields
    localparam int PAUSE_BIT = 7;
    localparam int CKSEL_LSB = 4;
    localparam int ON_BIT    = 3;
    // Control 1 fields
    localparam int MODE_LSB  = 6;
    localparam int IO_LSB    = 4;
    localparam int OC_BIT    = 3;
    localparam int POL_BIT   = 2;
    localparam int CCLR_BIT  = 0;
    // Interrupt status bits
    localparam int IRQ_A_BIT = 0;
    localparam int IRQ_P_BIT = 1;

    localparam logic [7:0]  BYTE_ZERO   = 8'h00;
    localparam logic [7:0]  CTRL0_WMASK = 8'hF8;
    localparam logic [15:0] CNT_ONE     = 16'h0001;
    localparam logic [3:0]  SYS_DIV4_M1 = 4'h3;
    localparam logic [5:0]  H_DIV16_M1  = 6'h0F;
    localparam logic [5:0]  H_DIV64_M1  = 6'h3F;

    typedef enum logic [2:0]
    {
        CK_SYS4  = 3'h0,
        CK_SYS   = 3'h1,
        CK_H16   = 3'h2,
        CK_H64   = 3'h3,
        CK_SUB0  = 3'h4,
        CK_SUB1  = 3'h5,
        CK_PINR  = 3'h6,
        CK_PINF  = 3'h7
    } tmc_cksel_t;

    typedef enum logic [1:0]
    {
        MD_CMP   = 2'h0,
        MD_UNDEF = 2'h1,
        MD_PWM   = 2'h2,
        MD_TIMER = 2'h3
    } tmc_mode_t;

    typedef enum logic [1:0]
    {
        IO_NONE   = 2'h0,
        IO_LOW    = 2'h1,
        IO_HIGH   = 2'h2,
        IO_TOGGLE = 2'h3
    } tmc_io_t;

    localparam logic [1:0] PD0_PTP_CODE = 2'h2;

    // Single pulse state along Gray path
    typedef enum logic [1:0]
    {
        SP_IDLE  = 2'b00,
        SP_PULSE = 2'b01,
        SP_DONE  = 2'b11
    } tmc_sp_t;
endpackage

// >>> tmc_sync.sv
`timescale 1ns/1ps
module tmc_sync
(
    input  wire logic clk_i,
    input  wire logic resetn_i,
    input  wire logic d_i,
    output logic      q_o
);
    logic meta;

    always_ff @(posedge clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            meta <= 1'b0;
            q_o  <= 1'b0;
        end
        else
        begin
            meta <= d_i;
            q_o  <= meta;
        end
    end
endmodule // tmc_sync

// >>> tmc_tick.sv
`timescale 1ns/1ps
module tmc_tick
(
    input  wire logic                clk_i,
    input  wire logic                resetn_i,
    input  wire tmc_pkg::tmc_cksel_t sel_i,
    input  wire logic                h_tick_i,
    input  wire logic                sub_tick_i,
    input  wire logic                pin_rise_i,
    input  wire logic                pin_fall_i,
    output logic                     tick_o
);
    import tmc_pkg::*;

    logic [3:0] sys_div;
    logic [5:0] h_div;
    wire        sys4_tick = (sys_div == SYS_DIV4_M1);
    wire        h16_tick  = h_tick_i && (h_div[3:0] == H_DIV16_M1[3:0]);
    wire        h64_tick  = h_tick_i && (h_div == H_DIV64_M1);

    always_ff @(posedge clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            sys_div <= 4'h0;
            h_div   <= 6'h00;
        end
        else
        begin
            sys_div <= sys4_tick ? 4'h0 : sys_div + 4'h1;
            if (h_tick_i)
                h_div <= h_div + 6'h01;
        end
    end

    always_comb
    begin
        case (sel_i)
            CK_SYS4: tick_o = sys4_tick;
            CK_SYS:  tick_o = 1'b1;
            CK_H16:  tick_o = h16_tick;
            CK_H64:  tick_o = h64_tick;
            CK_SUB0: tick_o = sub_tick_i;
            CK_SUB1: tick_o = sub_tick_i;
            CK_PINR: tick_o = pin_rise_i;
            CK_PINF: tick_o = pin_fall_i;
            default: tick_o = 1'b0;
        endcase
    end
endmodule // tmc_tick

// >>> tmc_top.sv
`timescale 1ns/1ps
module tmc_top
(
    input  wire logic        clk_i,
    input  wire logic        resetn_i,
    input  wire logic        psel_i,
    input  wire logic        penable_i,
    input  wire logic        pwrite_i,
    input  wire logic [11:0] paddr_i,
    input  wire logic [31:0] pwdata_i,
    output logic      [31:0] prdata_o,
    output logic             pready_o,
    output logic             pslverr_o,
    input  wire logic        h_tick_i,
    input  wire logic        sub_tick_i,
    input  wire logic        timer_event_clock_pin_i,
    output logic             timer_output_pin_o,
    output logic             periodic_timer_output_pin_o,
    output logic             pd0_gpio_select_o,
    output logic             irq_o
);
    import tmc_pkg::*;

    logic [7:0]  ctrl0;
    logic [7:0]  ctrl1;
    logic [15:0] counter;
    logic [15:0] compare_a_value;
    logic [15:0] compare_p_value;
    logic [7:0]  hold_buf;
    logic [1:0]  int_stat;
    logic [1:0]  int_mask;
    logic [7:0]  portd_function_select;
    logic        on_q;
    logic        pin_s;
    logic        pin_q;
    logic        out_lvl;
    logic        tick;
    tmc_sp_t     sp_state;
    tmc_sp_t     next_sp_state;

    // Bus phases
    wire        acc     = psel_i && penable_i;
    wire        wr      = acc && pwrite_i;
    wire        rd      = acc && !pwrite_i;
    wire [7:0]  wbyte   = pwdata_i[7:0];

    // Control fields
    wire        run_on  = ctrl0[ON_BIT];
    wire        paused  = ctrl0[PAUSE_BIT];
    wire        turn_on = run_on && !on_q;
    tmc_cksel_t cksel;
    tmc_mode_t  mode;
    tmc_io_t    io_sel;
    assign cksel  = tmc_cksel_t'(ctrl0[CKSEL_LSB +: 3]);
    assign mode   = tmc_mode_t'(ctrl1[MODE_LSB +: 2]);
    assign io_sel = tmc_io_t'(ctrl1[IO_LSB +: 2]);
    wire   init_lvl = ctrl1[OC_BIT];
    wire   clr_on_a = ctrl1[CCLR_BIT];

    // Matches are judged on the count being left, once per tick
    wire        step    = run_on && !paused && tick;
    wire        match_a = step && (counter == compare_a_value);
    wire        match_p = step && (counter == compare_p_value);
    wire        clr_cnt_a = match_a && clr_on_a;
    wire        clr_cnt_p = match_p && !clr_on_a;
    wire        clr_cnt = clr_cnt_a || clr_cnt_p;
    wire [15:0] next_counter = turn_on ? {BYTE_ZERO, BYTE_ZERO} :
                               clr_cnt ? {BYTE_ZERO, BYTE_ZERO} :
                               step    ? counter + CNT_ONE : counter;

    // Edge detect on the synchronised pin only
    wire pin_rise = pin_s && !pin_q;
    wire pin_fall = !pin_s && pin_q;

    // Address decode
    wire hit_c0  = (paddr_i == CTRL0_ADDR);
    wire hit_c1  = (paddr_i == CTRL1_ADDR);
    wire hit_dl  = (paddr_i == CNT_LO_ADDR);
    wire hit_dh  = (paddr_i == CNT_HI_ADDR);
    wire hit_al  = (paddr_i == CMPA_LO_ADDR);
    wire hit_ah  = (paddr_i == CMPA_HI_ADDR);
    wire hit_pl  = (paddr_i == CMPP_LO_ADDR);
    wire hit_ph  = (paddr_i == CMPP_HI_ADDR);
    wire hit_is  = (paddr_i == INT_STAT_ADDR);
    wire hit_im  = (paddr_i == INT_MASK_ADDR);
    wire hit_pd  = (paddr_i == PDSEL_ADDR);
    wire mapped  = hit_c0 || hit_c1 || hit_dl || hit_dh || hit_al || hit_ah ||
                   hit_pl || hit_ph || hit_is || hit_im || hit_pd;

    // Low-byte reads see the buffer, never the live byte
    wire [7:0] rd_byte =
        hit_c0 ? ctrl0 :
        hit_c1 ? ctrl1 :
        (hit_dl || hit_al || hit_pl) ? hold_buf :
        hit_dh ? counter[15:8] :
        hit_ah ? compare_a_value[15:8] :
        hit_ph ? compare_p_value[15:8] :
        hit_is ? {6'h00, int_stat} :
        hit_im ? {6'h00, int_mask} :
        hit_pd ? portd_function_select : BYTE_ZERO;

    // Capture for a high read, load for a compare low write
    wire [7:0] next_hold_buf =
        (rd && hit_dh) ? counter[7:0] :
        (rd && hit_ah) ? compare_a_value[7:0] :
        (rd && hit_ph) ? compare_p_value[7:0] :
        (wr && (hit_al || hit_pl)) ? wbyte : hold_buf;

    // Set wins over a write-one clear
    wire [1:0] evt = {match_p, match_a};
    wire [1:0] w1c = (wr && hit_is) ? pwdata_i[1:0] : 2'h0;
    wire [1:0] next_int_stat = evt | (int_stat & ~w1c);

    // Single pulse: pin edge starts a pulse, compare A ends it
    always_comb
    begin
        case (sp_state)
            SP_IDLE:  next_sp_state = (run_on && pin_rise) ? SP_PULSE : SP_IDLE;
            SP_PULSE: next_sp_state = match_a ? SP_DONE : SP_PULSE;
            SP_DONE:  next_sp_state = run_on ? SP_DONE : SP_IDLE;
            default:  next_sp_state = SP_IDLE;
        endcase
    end
    wire sp_mode = (mode == MD_UNDEF);

    // Output level for compare match, PWM and single pulse
    logic next_out_lvl;
    always_comb
    begin
        next_out_lvl = out_lvl;
        if (turn_on)
            next_out_lvl = init_lvl;
        else if (mode == MD_CMP && match_a)
        begin
            case (io_sel)
                IO_LOW:    next_out_lvl = 1'b0;
                IO_HIGH:   next_out_lvl = 1'b1;
                IO_TOGGLE: next_out_lvl = !out_lvl;
                default:   next_out_lvl = out_lvl;
            endcase
        end
        else if (mode == MD_PWM)
        begin
            // With IO_HIGH, active until compare A, inactive to period end
            case (io_sel)
                IO_NONE:   next_out_lvl = !init_lvl;
                IO_LOW:    next_out_lvl = init_lvl;
                IO_HIGH:   next_out_lvl = (match_p || turn_on) ? init_lvl :
                                          match_a ? !init_lvl : out_lvl;
                default:   next_out_lvl = out_lvl;
            endcase
        end
        else if (sp_mode)
            next_out_lvl = (next_sp_state == SP_PULSE) ? init_lvl : !init_lvl;
    end

    wire [31:0] next_prdata = (rd && mapped) ? {24'h000000, rd_byte} : 32'h00000000;

    tmc_sync u_pin_sync
    (
        .clk_i    (clk_i),
        .resetn_i (resetn_i),
        .d_i      (timer_event_clock_pin_i),
        .q_o      (pin_s)
    );

    tmc_tick u_tick
    (
        .clk_i      (clk_i),
        .resetn_i   (resetn_i),
        .sel_i      (cksel),
        .h_tick_i   (h_tick_i),
        .sub_tick_i (sub_tick_i),
        .pin_rise_i (pin_rise),
        .pin_fall_i (pin_fall),
        .tick_o     (tick)
    );

    always_ff @(posedge clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            ctrl0 <= BYTE_ZERO;
            ctrl1 <= BYTE_ZERO;
            int_mask <= 2'h0;
            portd_function_select <= BYTE_ZERO;
        end
        else if (wr)
        begin
            if (hit_c0)
                ctrl0 <= wbyte & CTRL0_WMASK;
            if (hit_c1)
                ctrl1 <= wbyte;
            if (hit_im)
                int_mask <= wbyte[1:0];
            if (hit_pd)
                portd_function_select <= wbyte;
        end
    end

    // High write takes buffer into low byte together
    always_ff @(posedge clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            compare_a_value <= {BYTE_ZERO, BYTE_ZERO};
            compare_p_value <= {BYTE_ZERO, BYTE_ZERO};
        end
        else if (wr)
        begin
            if (hit_ah)
                compare_a_value <= {wbyte, hold_buf};
            if (hit_ph)
                compare_p_value <= {wbyte, hold_buf};
        end
    end

    always_ff @(posedge clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            counter  <= {BYTE_ZERO, BYTE_ZERO};
            hold_buf <= BYTE_ZERO;
            int_stat <= 2'h0;
            on_q     <= 1'b0;
            pin_q    <= 1'b0;
            out_lvl  <= 1'b0;
            sp_state <= SP_IDLE;
        end
        else
        begin
            counter  <= next_counter;
            hold_buf <= next_hold_buf;
            int_stat <= next_int_stat;
            on_q     <= run_on;
            pin_q    <= pin_s;
            out_lvl  <= next_out_lvl;
            sp_state <= sp_mode ? next_sp_state : SP_IDLE;
        end
    end

    always_ff @(posedge clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            prdata_o  <= 32'h00000000;
            pready_o  <= 1'b0;
            pslverr_o <= 1'b0;
            irq_o     <= 1'b0;
            timer_output_pin_o          <= 1'b0;
            periodic_timer_output_pin_o <= 1'b0;
            pd0_gpio_select_o           <= 1'b1;
        end
        else
        begin
            // One wait state: answer in the second access cycle
            pready_o  <= psel_i && penable_i && !pready_o;
            pslverr_o <= psel_i && penable_i && !pready_o && !mapped;
            prdata_o  <= next_prdata;
            irq_o     <= |(next_int_stat & int_mask);
            timer_output_pin_o <= next_out_lvl;
            periodic_timer_output_pin_o <=
                (portd_function_select[1:0] == PD0_PTP_CODE) && next_out_lvl;
            // Reserved code keeps the pin on general I/O
            pd0_gpio_select_o <= (portd_function_select[1:0] != PD0_PTP_CODE);
        end
    end
endmodule // tmc_top

// >>> tmc_properties.sv
`timescale 1ns/1ps
module tmc_properties
    import tmc_pkg::*;
(
    input wire logic        clk_i,
    input wire logic        resetn_i,
    input wire logic        psel_i,
    input wire logic        penable_i,
    input wire logic        pwrite_i,
    input wire logic [11:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    input wire logic [31:0] prdata_o,
    input wire logic        pready_o,
    input wire logic        pslverr_o,
    input wire logic        periodic_timer_output_pin_o,
    input wire logic        pd0_gpio_select_o,
    input wire logic        irq_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (!resetn_i);

    wire mapped = (paddr_i[1:0] == 2'h0) && (paddr_i <= PDSEL_ADDR);
    wire access = psel_i && penable_i;

    a_ready_one_wait: assert property (
        access && !$past(penable_i) |-> !pready_o ##1 pready_o) else $error("ready timing off");
    a_ready_one_pulse: assert property (pready_o |=> !pready_o)
        else $error("ready held too long");
    a_ready_in_access: assert property (pready_o |-> access)
        else $error("ready outside access");
    a_err_with_ready: assert property (pslverr_o |-> pready_o)
        else $error("error without ready");
    a_unmapped_err: assert property (pready_o |-> pslverr_o == !mapped)
        else $error("error flag wrong for address");
    a_read_upper_zero: assert property (
        pready_o && !pwrite_i |-> prdata_o[31:8] == 24'h000000) else $error("upper read bits set");
    a_err_data_zero: assert property (pslverr_o |-> prdata_o == 32'h00000000)
        else $error("data on refused access");
    a_pd0_exclusive: assert property (
        periodic_timer_output_pin_o |-> !pd0_gpio_select_o) else $error("pin routed twice");
    a_mask_quiets_irq: assert property (
        pready_o && pwrite_i && paddr_i == INT_MASK_ADDR && pwdata_i[1:0] == 2'h0
        |=> !irq_o) else $error("masked interrupt still high");

    cover property (pslverr_o);
    cover property (irq_o);
    cover property (pready_o && !pwrite_i && paddr_i == CNT_LO_ADDR);
endmodule // tmc_properties

bind tmc_top tmc_properties u_props
(
    .clk_i, .resetn_i, .psel_i, .penable_i, .pwrite_i, .paddr_i, .pwdata_i, .prdata_o,
    .pready_o, .pslverr_o, .periodic_timer_output_pin_o, .pd0_gpio_select_o, .irq_o
);

// >>> tmc_pin_model.sv
`timescale 1ns/1ps
module tmc_pin_model
(
    input  wire logic clk_i,
    output logic      event_pin_o,
    output logic      h_tick_o,
    output logic      sub_tick_o
);
    logic [3:0] div = 4'h0;

    initial event_pin_o = 1'b0;
    always @(posedge clk_i) div <= div + 4'h1;
    assign h_tick_o   = div[0];
    assign sub_tick_o = (div == 4'hF);

    // Slow toggles so the two-flop synchroniser sees every edge
    task automatic send_edges(input int n);
        repeat (n)
        begin
            repeat (4) @(posedge clk_i);
            event_pin_o <= ~event_pin_o;
        end
        repeat (6) @(posedge clk_i);
    endtask
endmodule // tmc_pin_model

// >>> tmc_tb_top.sv
`timescale 1ns/1ps
module tmc_tb_top;
    import tmc_pkg::*;
    logic        clk_i     = 1'b0;
    logic        resetn_i  = 1'b0;
    logic        psel_i    = 1'b0;
    logic        penable_i = 1'b0;
    logic        pwrite_i  = 1'b0;
    logic [11:0] paddr_i   = 12'h000;
    logic [31:0] pwdata_i  = 32'h00000000;
    logic [31:0] prdata_o;
    logic [31:0] rd;
    logic        pready_o, pslverr_o, h_tick_i, sub_tick_i, pin, tout, pout, gsel, irq_o, err;
    int          miscompares = 0;
    int          comparisons = 0;

    always #5 clk_i = ~clk_i;

    tmc_top dut
    (
        .clk_i, .resetn_i, .psel_i, .penable_i, .pwrite_i, .paddr_i, .pwdata_i, .prdata_o,
        .pready_o, .pslverr_o, .h_tick_i, .sub_tick_i, .timer_event_clock_pin_i(pin),
        .timer_output_pin_o(tout), .periodic_timer_output_pin_o(pout),
        .pd0_gpio_select_o(gsel), .irq_o
    );
    tmc_pin_model u_pins (.clk_i, .event_pin_o(pin), .h_tick_o(h_tick_i), .sub_tick_o(sub_tick_i));

    task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp)
        begin
            miscompares++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic chk_bit(input logic got, input logic exp);
        chk_word({31'h0, got}, {31'h0, exp});
    endtask

    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk_i);
        psel_i   <= 1'b1;
        pwrite_i <= wr;
        paddr_i  <= a;
        pwdata_i <= d;
        @(posedge clk_i);
        penable_i <= 1'b1;
        // Look mid-cycle: answer is settled and stands until the next edge
        do
        begin
            @(negedge clk_i);
            n++;
        end
        while (pready_o !== 1'b1 && n < 50);
        if (pready_o !== 1'b1)
            miscompares++;
        rd  = prdata_o;
        err = pslverr_o;
        @(posedge clk_i);
        psel_i    <= 1'b0;
        penable_i <= 1'b0;
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
        chk_bit(err, 1'b0);
    endtask

    task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        chk_word(rd, exp);
        chk_bit(err, 1'b0);
    endtask

    task automatic tally_and_finish;
        $display("comparisons %0d miscompares %0d", comparisons, miscompares);
        if (miscompares == 0 && comparisons > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    initial
    begin
        #300000;
        miscompares++;
        tally_and_finish();
    end

    initial
    begin
        repeat (16) @(posedge clk_i);
        resetn_i <= 1'b1;
        @(posedge clk_i);
        chk_bit(gsel, 1'b1);
        rd_chk(PDSEL_ADDR, 32'h0);
        for (int c = 0; c < 4; c++)
        begin
            wr(PDSEL_ADDR, 32'(c));
            rd_chk(PDSEL_ADDR, 32'(c));
            repeat (2) @(posedge clk_i);
            chk_bit(gsel, c != 2);
        end
        wr(PDSEL_ADDR, 32'h2);
        apb(1'b0, 12'h02C, 32'h0);
        chk_bit(err, 1'b1);
        apb(1'b1, 12'h030, 32'hFF);
        chk_bit(err, 1'b1);
        wr(CMPA_LO_ADDR, 32'h05);
        rd_chk(CMPA_HI_ADDR, 32'h0);
        rd_chk(CMPA_LO_ADDR, 32'h0);
        wr(CMPA_LO_ADDR, 32'h05);
        wr(CMPA_HI_ADDR, 32'h0);
        wr(CMPP_LO_ADDR, 32'h34);
        wr(CMPP_HI_ADDR, 32'h12);
        rd_chk(CMPP_HI_ADDR, 32'h12);
        rd_chk(CMPP_LO_ADDR, 32'h34);
        rd_chk(CMPA_HI_ADDR, 32'h0);
        rd_chk(CMPA_LO_ADDR, 32'h05);
        wr(INT_MASK_ADDR, 32'h3);
        wr(CTRL1_ADDR, 32'h30);
        wr(CTRL0_ADDR, 32'h68);
        u_pins.send_edges(6);
        rd_chk(CNT_HI_ADDR, 32'h0);
        rd_chk(CNT_LO_ADDR, 32'h3);
        chk_bit(irq_o, 1'b0);
        u_pins.send_edges(6);
        rd_chk(INT_STAT_ADDR, 32'h1);
        chk_bit(irq_o, 1'b1);
        chk_bit(tout, 1'b1);
        chk_bit(pout, 1'b1);
        wr(INT_MASK_ADDR, 32'h0);
        repeat (2) @(posedge clk_i);
        chk_bit(irq_o, 1'b0);
        wr(INT_STAT_ADDR, 32'h1);
        rd_chk(INT_STAT_ADDR, 32'h0);
        wr(INT_MASK_ADDR, 32'h3);
        wr(CTRL0_ADDR, 32'h70);
        u_pins.send_edges(2);
        rd_chk(CNT_HI_ADDR, 32'h0);
        rd_chk(CNT_LO_ADDR, 32'h6);
        wr(CTRL0_ADDR, 32'h78);
        u_pins.send_edges(3);
        rd_chk(CNT_HI_ADDR, 32'h0);
        rd_chk(CNT_LO_ADDR, 32'h1);
        wr(CTRL0_ADDR, 32'h40);
        wr(CTRL1_ADDR, 32'h48);
        wr(CTRL0_ADDR, 32'h48);
        u_pins.send_edges(2);
        chk_bit(tout, 1'b1);
        repeat (200) @(posedge clk_i);
        chk_bit(tout, 1'b0);
        tally_and_finish();
    end
endmodule // tmc_tb_top
